// File: eeprom_program_erase_ctrl.sv
// Summary of operation
// R1: Array at default page, moved by map register
// R2: Array accessible only while array_enable set
// R3: Guard bits block program/erase; low-voltage protect
// R4: Pump clock select uses internal oscillator
// R5: Special modes expose extra test row
// R6: Erased bytes read back as all ones
// R7: No array writes while high voltage on
// R8: Odd and even set programs half-array rows
// R9: Byte/row bits choose byte, row, bulk
// R10: Erase bit selects erase versus program
// R11: Latch bit captures next write address, data
// R12: Reads ignore block guard bits
// R13: High voltage writable only while latch set
// R14: Latch clear forces high voltage off
// R15: Program ignores byte and row bits
// R16: Software erases before programming
// R17: Sequence: setup, target write, voltage, wait, clear
// R18: Setup byte programmable unless setup guard set
// R19: Setup change: erase, program, then reset
// R20: Reads return latches; programming hits cells
// R21: Latches load from cells only at reset
// R22: Special mode allows direct setup writes
// R23: No hardware timeout on high voltage
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module eeprom_program_erase_ctrl (
   // Clock, reset, enable
   input  wire logic        core_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        clk_en_i,
   // Special mode strap pin
   input  wire logic        special_mode_flag_i,
   // Low-voltage detector pin
   input  wire logic        low_voltage_i,
   // Register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [7:0]  reg_rdata_o,
   // CPU memory port
   input  wire logic [15:0] mem_addr_i,
   input  wire logic [7:0]  mem_wdata_i,
   input  wire logic        mem_wr_i,
   input  wire logic        mem_rd_i,
   output logic      [7:0]  mem_rdata_o,
   output logic             mem_hit_o,
   // Status
   output logic             hv_on_o,
   output logic             pump_clk_o
);
   import nv_pkg::*;

   // ==========================================================
   // Reset and pin conditioning
   logic rst_n;
   logic special_mode_flag_lvl;
   logic lv_lvl;

   nv_reset_sync u_rst (
      .core_clk_i (core_clk_i),
      .rstn_i     (rstn_i),
      .rst_n_o    (rst_n)
   );

   nv_pin_sync u_special_mode_flag (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n),
      .ce_i       (clk_en_i),
      .pin_i      (special_mode_flag_i),
      .level_o    (special_mode_flag_lvl)
   );

   nv_pin_sync u_lv (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n),
      .ce_i       (clk_en_i),
      .pin_i      (low_voltage_i),
      .level_o    (lv_lvl)
   );

   // ==========================================================
   // Storage: array cells plus test row, setup cell and latches
   logic [7:0]        cell_r [0:ARRAY_BYTES+ROW_BYTES-1];
   logic [7:0]        setup_cell_r;
   logic [7:0]        setup_lat_r;
   logic              setup_loaded_r;
   logic [7:0]        ctrl_r;
   logic [7:0]        guard_r;
   logic [3:0]        map_page_r;
   logic              pump_sel_r;
   logic [ADDR_W-1:0] tgt_addr_r;
   logic [7:0]        tgt_data_r;
   logic              tgt_setup_r;
   logic              tgt_valid_r;
   logic [7:0]        ctrl_prev_r;

   // ==========================================================
   // Address decode
   logic [15:0]       base;
   logic [15:0]       offs;
   logic [ADDR_W-1:0] idx;
   logic              in_array;
   logic              setup_hit;
   logic              op_busy;

   assign base = {map_page_r, PAGE_OFS};                             // R1
   assign offs = mem_addr_i - base;
   assign idx  = offs[ADDR_W-1:0];
   assign in_array = setup_loaded_r && setup_lat_r[B_ARRAY_EN]       // R2
      && (mem_addr_i >= base)
      && (offs[15:ADDR_W] == '0)
      && ((idx <= ARRAY_LAST) || (special_mode_flag_lvl && idx <= TEST_LAST));    // R5
   assign setup_hit = (mem_addr_i == {8'h00, OFS_SETUP});
   assign op_busy   = ctrl_r[B_HV];

   // ==========================================================
   // Operation decode
   op_kind_t op;

   // Byte wins over row; program ignores both; copy held before voltage went off
   always_comb begin
      if (!ctrl_prev_r[B_ERASE]) begin                               // R10
         op = OP_PROG;                                               // R15
      end else if (ctrl_prev_r[B_BYTE]) begin                        // R9
         op = OP_BYTE;
      end else if (ctrl_prev_r[B_ROW]) begin
         op = OP_ROW;
      end else begin
         op = OP_BULK;
      end
   end

   // Block guard for a byte index; low voltage guards everything when the low-voltage protect bit is set
   function automatic logic guarded(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] blk;
      blk = a / BLOCK_SZ;
      if (guard_r[B_LV_PROT] && lv_lvl) begin
         guarded = 1'b1;
      end else if (blk < ADDR_W'(N_BLOCKS)) begin
         guarded = guard_r[blk[2:0]];                                // R3
      end else begin
         guarded = 1'b0;
      end
   endfunction

   // ==========================================================
   // Control register; high voltage needs latch bit
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RESET;
      end else if (clk_en_i && reg_wr_i && reg_addr_i == OFS_PROG_CTRL) begin
         ctrl_r <= reg_wdata_i & CTRL_MASK;
         // Voltage bit takes the write only with latch already set
         ctrl_r[B_HV] <= reg_wdata_i[B_HV] && ctrl_r[B_LATCH]        // R13
                         && reg_wdata_i[B_LATCH];                    // R14
      end
   end

   // Guard, map and option registers
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         guard_r    <= GUARD_RESET;
         map_page_r <= MAP_PAGE_RST;
         pump_sel_r <= 1'b0;
      end else if (clk_en_i && reg_wr_i) begin
         if (reg_addr_i == OFS_GUARD) begin
            guard_r <= reg_wdata_i;
         end
         if (reg_addr_i == OFS_MAP_POS) begin
            map_page_r <= reg_wdata_i[3:0];                          // R1
         end
         if (reg_addr_i == OFS_OPTION) begin
            pump_sel_r <= reg_wdata_i[B_PUMP_CLK];
         end
      end
   end

   // ==========================================================
   // Target capture; a second location is refused mid-operation unless the first was the setup byte
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tgt_addr_r  <= '0;
         tgt_data_r  <= ERASED;
         tgt_setup_r <= 1'b0;
         tgt_valid_r <= 1'b0;
      end else if (clk_en_i) begin
         if (!ctrl_r[B_LATCH]) begin
            tgt_valid_r <= 1'b0;
         end else if (mem_wr_i && !op_busy) begin                    // R7
            if (in_array && (!tgt_valid_r || tgt_setup_r || idx == tgt_addr_r)) begin
               tgt_addr_r  <= idx;                                   // R11
               tgt_data_r  <= mem_wdata_i;
               tgt_setup_r <= 1'b0;
               tgt_valid_r <= 1'b1;
            end else if (setup_hit && (!tgt_valid_r || tgt_setup_r)) begin
               tgt_setup_r <= 1'b1;
               tgt_data_r  <= mem_wdata_i;
               tgt_valid_r <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Cell update at voltage turn-off; no timeout, software times it
   logic hv_fall;
   assign hv_fall = ctrl_prev_r[B_HV] && !ctrl_r[B_HV];              // R23

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_prev_r <= CTRL_RESET;
      end else if (clk_en_i) begin
         ctrl_prev_r <= ctrl_r;
      end
   end

   genvar g;
   generate
      for (g = 0; g < ARRAY_BYTES + ROW_BYTES; g++) begin : g_cell
         localparam logic [ADDR_W-1:0] GI = ADDR_W'(g);
         logic hit;
         always_comb begin
            case (op)
               OP_BYTE: hit = (GI == tgt_addr_r);
               OP_ROW:  hit = (GI / ROW_BYTES) == (tgt_addr_r / ROW_BYTES);
               OP_BULK: hit = (GI <= ARRAY_LAST);
               default: begin
                  if (ctrl_prev_r[B_ODD] && ctrl_prev_r[B_EVEN]) begin // R8
                     hit = (GI <= ARRAY_LAST)
                        && ((GI / ADDR_W'(ARRAY_BYTES/2)) == (tgt_addr_r / ADDR_W'(ARRAY_BYTES/2)))
                        && (GI % ROW_BYTES) == (tgt_addr_r % ROW_BYTES);
                  end else begin
                     hit = (GI == tgt_addr_r);
                  end
               end
            endcase
         end
         // Cells are not reset: contents survive reset
         always_ff @(posedge core_clk_i) begin
            if (clk_en_i && hv_fall && tgt_valid_r && !tgt_setup_r && hit
                && !guarded(GI)) begin                               // R3
               if (op == OP_PROG) begin
                  cell_r[g] <= cell_r[g] & tgt_data_r;               // R16
               end else begin
                  cell_r[g] <= ERASED;                               // R6
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // Setup cell and its working latch
   logic setup_nv_ok;
   logic lv_block;
   assign lv_block    = guard_r[B_LV_PROT] && lv_lvl;
   assign setup_nv_ok = !guard_r[B_SETUP_GUARD] && !lv_block;        // R18

   always_ff @(posedge core_clk_i) begin
      if (clk_en_i && hv_fall && tgt_valid_r && tgt_setup_r && setup_nv_ok) begin
         if (op == OP_PROG) begin
            setup_cell_r <= (setup_cell_r & tgt_data_r) | SETUP_FORCE; // R20
         end else begin
            setup_cell_r <= ERASED;
         end
      end
   end

   // Latch loads once after reset release; afterwards only direct writes
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         setup_lat_r    <= SETUP_FORCE;
         setup_loaded_r <= 1'b0;
      end else if (clk_en_i) begin
         if (!setup_loaded_r) begin
            setup_lat_r    <= setup_cell_r | SETUP_FORCE;            // R21
            setup_loaded_r <= 1'b1;
         end else if (special_mode_flag_lvl && reg_wr_i && reg_addr_i == OFS_SETUP) begin
            setup_lat_r <= reg_wdata_i | SETUP_FORCE;                // R22
         end
      end
   end

   // ==========================================================
   // Register read port, data one cycle later
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_o <= 8'h00;
      end else if (clk_en_i) begin
         if (reg_rd_i) begin
            case (reg_addr_i)
               OFS_PROG_CTRL: reg_rdata_o <= ctrl_r;
               OFS_SETUP:     reg_rdata_o <= setup_lat_r;            // R20
               OFS_GUARD:     reg_rdata_o <= guard_r;
               OFS_MAP_POS:   reg_rdata_o <= {4'h0, map_page_r};
               OFS_OPTION:    reg_rdata_o <= {1'b0, pump_sel_r, 6'h00};
               default:       reg_rdata_o <= 8'h00;
            endcase
         end else begin
            reg_rdata_o <= 8'h00;
         end
      end
   end

   // Array read, unaffected by guards; latch set gives no ROM read
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         mem_rdata_o <= 8'h00;
         mem_hit_o   <= 1'b0;
      end else if (clk_en_i) begin
         mem_hit_o   <= mem_rd_i && in_array;                        // R12
         if (mem_rd_i && in_array && !ctrl_r[B_LATCH]) begin         // R11
            mem_rdata_o <= cell_r[idx];
         end else begin
            mem_rdata_o <= 8'h00;
         end
      end
   end

   // ==========================================================
   // Pump clock: divided oscillator when selected, else held high while voltage is on
   logic [3:0] pump_cnt_r;
   logic       pump_osc_r;

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pump_cnt_r <= 4'h0;
         pump_osc_r <= 1'b0;
      end else if (clk_en_i) begin
         if (pump_cnt_r == PUMP_DIV) begin
            pump_cnt_r <= 4'h0;
            pump_osc_r <= !pump_osc_r;
         end else begin
            pump_cnt_r <= pump_cnt_r + 4'h1;
         end
      end
   end

   assign pump_clk_o = ctrl_r[B_HV] && (pump_sel_r ? pump_osc_r : 1'b1); // R4
   assign hv_on_o    = ctrl_r[B_HV];                                 // R13
endmodule // eeprom_program_erase_ctrl
`default_nettype wire

// File: nv_pkg.sv
package nv_pkg;
   // ==========================================================
   // Register map (byte offsets on the register port)
   localparam logic [7:0] OFS_PROG_CTRL  = 8'h3b;
   localparam logic [7:0] OFS_SETUP      = 8'h3f;
   localparam logic [7:0] OFS_GUARD      = 8'h35;
   localparam logic [7:0] OFS_MAP_POS    = 8'h3d;
   localparam logic [7:0] OFS_OPTION     = 8'h39;
   // ==========================================================
   // Control register fields
   localparam int B_HV    = 0;
   localparam int B_LATCH = 1;
   localparam int B_ERASE = 2;
   localparam int B_ROW   = 3;
   localparam int B_BYTE  = 4;
   localparam int B_EVEN  = 6;
   localparam int B_ODD   = 7;
   localparam logic [7:0] CTRL_MASK   = 8'hdf;
   localparam logic [7:0] CTRL_RESET  = 8'h00;
   // Setup byte fields
   localparam int B_ARRAY_EN          = 0;
   localparam logic [7:0] SETUP_FORCE = 8'hc2;
   // Guard register: bit 7 low-voltage protect, bits 4..0 block guards, bit 4 also setup guard
   localparam int B_SETUP_GUARD       = 4;
   localparam int B_LV_PROT           = 7;
   localparam int N_BLOCKS            = 5;
   localparam logic [7:0] GUARD_RESET = 8'h1f;
   localparam int B_PUMP_CLK          = 6;
   // ==========================================================
   // Array geometry
   localparam int ARRAY_BYTES         = 640;
   localparam int ROW_BYTES           = 16;
   localparam int ADDR_W              = 10;
   localparam logic [9:0] ARRAY_LAST  = 10'h27f;
   localparam logic [9:0] TEST_LAST   = 10'h28f;
   localparam logic [9:0] BLOCK_SZ    = 10'h080;
   localparam logic [15:0] MAP_RESET  = 16'h0d80;
   localparam logic [7:0] ERASED      = 8'hff;
   localparam logic [3:0] MAP_PAGE_RST = 4'h0;
   localparam logic [11:0] PAGE_OFS   = 12'hd80;
   // Pump oscillator divide for slow bus clocks
   localparam logic [3:0] PUMP_DIV    = 4'h7;
   // Program time, software-timed; figure is informative
   localparam int PROGRAM_TIME_US     = 10;
   localparam int CLK_MHZ             = 40;
   localparam int PROGRAM_TIME_CYC    = PROGRAM_TIME_US * CLK_MHZ;
   // ==========================================================
   // Operation kinds
   typedef enum logic [3:0] {
      OP_PROG = 4'b0001,
      OP_BYTE = 4'b0010,
      OP_ROW  = 4'b0100,
      OP_BULK = 4'b1000
   } op_kind_t;
endpackage

// File: nv_reset_sync.sv
`timescale 1ns/1ps
`default_nettype none
module nv_reset_sync (
   // Clock and raw reset
   input  wire logic core_clk_i,
   input  wire logic rstn_i,
   // Released reset
   output logic      rst_n_o
);
   logic [1:0] sync_r;

   // Assert async, release after two edges
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync_r <= 2'b00;
      end else begin
         sync_r <= {sync_r[0], 1'b1};
      end
   end

   assign rst_n_o = sync_r[1];
endmodule // nv_reset_sync
`default_nettype wire

// File: nv_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module nv_pin_sync (
   // Clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic ce_i,
   // Pin in, filtered level out
   input  wire logic pin_i,
   output logic      level_o
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   // Three stages; level moves once stages two and three agree
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_r    <= 1'b0;
         s2_r    <= 1'b0;
         s3_r    <= 1'b0;
         level_o <= 1'b0;
      end else if (ce_i) begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            level_o <= s3_r;
         end
      end
   end
endmodule // nv_pin_sync
`default_nettype wire

// File: eeprom_program_erase_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Control register and voltage switch checks
module eeprom_ctrl_monitor
   import nv_pkg::*;
(
   // Clock, reset, enable
   input wire logic       core_clk_i,
   input wire logic       rstn_i,
   input wire logic       clk_en_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // Memory read and status
   input wire logic       mem_rd_i,
   input wire logic [7:0] mem_rdata_o,
   input wire logic       hv_on_o,
   input wire logic       pump_clk_o
);
   logic [7:0] ctrl_r;
   logic       wr_ctrl;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   // Shadow control register; voltage bit sticks only over a latch already set
   assign wr_ctrl = reg_wr_i && clk_en_i && reg_addr_i == OFS_PROG_CTRL;
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_r <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_r <= reg_wdata_i & CTRL_MASK & {7'h7f, ctrl_r[B_LATCH] & reg_wdata_i[B_LATCH]};
      end
   end
   // ==========================================================
   // Voltage switch steps
   sequence s_hv_req;
      wr_ctrl && reg_wdata_i[B_HV] && reg_wdata_i[B_LATCH] && ctrl_r[B_LATCH];
   endsequence
   sequence s_hv_hold;
      hv_on_o && !wr_ctrl;
   endsequence
   property p_hv_on; s_hv_req |=> hv_on_o; endproperty
   property p_hv_mirror; hv_on_o == ctrl_r[B_HV]; endproperty
   property p_latch_off; wr_ctrl && !reg_wdata_i[B_LATCH] |=> !hv_on_o; endproperty
   property p_hv_hold; s_hv_hold |=> hv_on_o; endproperty
   property p_hv_rise; $rose(hv_on_o) |-> $past(wr_ctrl); endproperty
   property p_pump; pump_clk_o |-> hv_on_o; endproperty
   // ==========================================================
   // Read answers
   property p_ctrl_read;
      reg_rd_i && clk_en_i && reg_addr_i == OFS_PROG_CTRL |=> reg_rdata_o == ctrl_r;
   endproperty
   property p_latch_read; mem_rd_i && clk_en_i && ctrl_r[B_LATCH] |=> mem_rdata_o == 8'h00; endproperty
   property p_setup_force;
      reg_rd_i && clk_en_i && reg_addr_i == OFS_SETUP |=> (reg_rdata_o & SETUP_FORCE) == SETUP_FORCE;
   endproperty
   a_hv_on: assert property (p_hv_on) else $error("voltage not on after arming write");
   a_hv_mirror: assert property (p_hv_mirror) else $error("voltage output differs from control bit");
   a_latch_off: assert property (p_latch_off) else $error("voltage on with latch cleared");
   a_hv_hold: assert property (p_hv_hold) else $error("voltage dropped without a write");
   a_hv_rise: assert property (p_hv_rise) else $error("voltage rose without a control write");
   a_pump: assert property (p_pump) else $error("pump clock runs with voltage off");
   a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
   a_latch_read: assert property (p_latch_read) else $error("array read while latched not zero");
   a_setup_force: assert property (p_setup_force) else $error("setup fixed ones missing");
endmodule // eeprom_ctrl_monitor

bind eeprom_program_erase_ctrl eeprom_ctrl_monitor i_eeprom_ctrl_monitor (.core_clk_i, .rstn_i, .clk_en_i,
   .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .mem_rd_i, .mem_rdata_o, .hv_on_o, .pump_clk_o);
`default_nettype wire

// File: nv_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// CPU side: register and memory strobes, programming sequences
module nv_cpu_model
   import nv_pkg::*;
#(
   parameter int PROG_HOLD = 40
)(
   // Clock
   input  wire logic   core_clk_i,
   // Register port
   output logic [7:0]  reg_addr_o,
   output logic [7:0]  reg_wdata_o,
   output logic        reg_wr_o,
   output logic        reg_rd_o,
   // Memory port
   output logic [15:0] mem_addr_o,
   output logic [7:0]  mem_wdata_o,
   output logic        mem_wr_o,
   output logic        mem_rd_o
);
   // Quiet bus at time zero
   initial begin
      {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = '0;
      {mem_addr_o, mem_wdata_o, mem_wr_o, mem_rd_o} = '0;
   end
   // One-cycle strobe; idle lines then flip so a stale value never matches
   task automatic reg_cyc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} <= {a, d, wr, !wr};
      @(posedge core_clk_i);
      {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} <= {~a, ~d, 2'b00};
   endtask
   task automatic mem_cyc(input logic wr, input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      {mem_addr_o, mem_wdata_o, mem_wr_o, mem_rd_o} <= {a, d, wr, !wr};
      @(posedge core_clk_i);
      {mem_addr_o, mem_wdata_o, mem_wr_o, mem_rd_o} <= {~a, ~d, 2'b00};
   endtask
   // Arm, capture, voltage on, wait, off, clear; the pulse is timed here
   task automatic nv_op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
      reg_cyc(1'b1, OFS_PROG_CTRL, c);
      mem_cyc(1'b1, a, d);
      reg_cyc(1'b1, OFS_PROG_CTRL, c | 8'h01);
      repeat (PROG_HOLD) @(posedge core_clk_i);
      reg_cyc(1'b1, OFS_PROG_CTRL, c);
      reg_cyc(1'b1, OFS_PROG_CTRL, 8'h00);
   endtask
   // Programming only ANDs bits in, so each byte is erased first
   task automatic prog(input logic [15:0] a, input logic [7:0] d);
      nv_op(8'h16, a, 8'h00);
      nv_op(8'h02, a, d);
   endtask
endmodule // nv_cpu_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench for the program and erase control
module testbench;
   import nv_pkg::*;
   logic        core_clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        clk_en_i = 1'b1;
   logic        special_mode_flag_i = 1'b0;
   logic        low_voltage_i = 1'b0;
   logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, mem_wdata_i, mem_rdata_o;
   logic        reg_wr_i, reg_rd_i, mem_wr_i, mem_rd_i, mem_hit_o, hv_on_o, pump_clk_o;
   logic [15:0] mem_addr_i;
   logic [15:0] adr[4] = '{16'h0d85, 16'h0d86, 16'h0d95, 16'h0d96};
   logic [7:0]  d[4];
   logic [7:0]  exp_q[$];
   logic        hit_q[$];
   logic        reg_pend = 1'b0;
   logic        mem_pend = 1'b0;
   int          n_fail = 0;
   int          check_count = 0;
   int          cyc = 0;
   // 40 MHz core clock
   always #12.5 core_clk_i = ~core_clk_i;
   eeprom_program_erase_ctrl i_eeprom_program_erase_ctrl (.core_clk_i, .rstn_i, .clk_en_i,
      .special_mode_flag_i, .low_voltage_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .mem_addr_i, .mem_wdata_i, .mem_wr_i, .mem_rd_i, .mem_rdata_o, .mem_hit_o,
      .hv_on_o, .pump_clk_o);
   nv_cpu_model i_nv_cpu_model (.core_clk_i, .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
      .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .mem_addr_o(mem_addr_i), .mem_wdata_o(mem_wdata_i),
      .mem_wr_o(mem_wr_i), .mem_rd_o(mem_rd_i));
   // ==========================================================
   // Compare, bus wrappers, closing
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      i_nv_cpu_model.reg_cyc(1'b1, a, v);
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_nv_cpu_model.reg_cyc(1'b0, a, 8'h00);
   endtask
   task automatic rd_mem(input logic [15:0] a, input logic [7:0] e, input logic h = 1'b1);
      exp_q.push_back(e);
      hit_q.push_back(h);
      i_nv_cpu_model.mem_cyc(1'b0, a, 8'h00);
   endtask
   task automatic hv_is(input logic e);
      @(negedge core_clk_i);
      cmp({7'h00, hv_on_o}, {7'h00, e});
   endtask
   task automatic pulse_reset();
      rstn_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Reads answer one cycle later; a ceiling cuts a hang
   always @(posedge core_clk_i) begin
      reg_pend <= reg_rd_i && clk_en_i;
      mem_pend <= mem_rd_i && clk_en_i;
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         n_fail++;
         $display("mismatch at %0t: run did not finish", $time);
         print_verdict();
      end
   end
   // Oldest note pairs with the answer now standing
   always @(negedge core_clk_i) begin
      if (reg_pend || mem_pend) begin
         cmp(reg_pend ? reg_rdata_o : mem_rdata_o, exp_q.pop_front());
      end
      if (mem_pend) begin
         cmp({7'h00, mem_hit_o}, {7'h00, hit_q.pop_front()});
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(32'hcca616f3));
      @(posedge core_clk_i);
      pulse_reset();
      rd_reg(OFS_PROG_CTRL, CTRL_RESET);
      rd_reg(OFS_GUARD, GUARD_RESET);
      rd_reg(8'h00, 8'h00);
      wr(OFS_PROG_CTRL, 8'h01);
      rd_reg(OFS_PROG_CTRL, 8'h00);
      wr(OFS_PROG_CTRL, 8'h03);
      rd_reg(OFS_PROG_CTRL, 8'h02);
      hv_is(1'b0);
      wr(OFS_PROG_CTRL, 8'h00);
      done("lock");
      // Direct setup writes only in special mode; pin sync needs a few cycles
      special_mode_flag_i <= 1'b1;
      repeat (8) @(posedge core_clk_i);
      wr(OFS_SETUP, 8'h01);
      rd_reg(OFS_SETUP, SETUP_FORCE | 8'h01);
      special_mode_flag_i <= 1'b0;
      repeat (8) @(posedge core_clk_i);
      wr(OFS_SETUP, 8'h00);
      rd_reg(OFS_SETUP, SETUP_FORCE | 8'h01);
      wr(OFS_GUARD, 8'h00);
      i_nv_cpu_model.nv_op(8'h06, 16'h0fff, 8'h00);
      rd_mem(16'h0d80, ERASED);
      rd_mem(16'h0fff, ERASED);
      done("setup and bulk");
      // Program with scope bits set, refused writes, long voltage hold
      d[0] = 8'($urandom());
      wr(OFS_PROG_CTRL, 8'h1a);
      i_nv_cpu_model.mem_cyc(1'b1, adr[0], d[0]);
      i_nv_cpu_model.mem_cyc(1'b1, 16'h0d86, 8'h00);
      wr(OFS_PROG_CTRL, 8'h1b);
      i_nv_cpu_model.mem_cyc(1'b1, 16'h0d90, 8'h00);
      rd_reg(OFS_PROG_CTRL, 8'h1b);
      rd_mem(adr[0], 8'h00);
      clk_en_i <= 1'b0;
      repeat (20) @(posedge core_clk_i);
      clk_en_i <= 1'b1;
      repeat (480) @(posedge core_clk_i);
      hv_is(1'b1);
      wr(OFS_PROG_CTRL, 8'h1a);
      wr(OFS_PROG_CTRL, 8'h00);
      hv_is(1'b0);
      rd_mem(adr[0], d[0]);
      rd_mem(16'h0d86, ERASED);
      rd_mem(16'h0d90, ERASED);
      for (int i = 1; i < 4; i++) begin
         d[i] = 8'($urandom());
         i_nv_cpu_model.prog(adr[i], d[i]);
      end
      done("program");
      // Map move, block guard
      wr(OFS_MAP_POS, 8'h02);
      rd_mem(16'h2d86, d[1]);
      rd_mem(16'h0d86, 8'h00, 1'b0);
      wr(OFS_MAP_POS, 8'h00);
      wr(OFS_GUARD, 8'h01);
      i_nv_cpu_model.prog(16'h0d87, 8'h00);
      rd_mem(16'h0d87, ERASED);
      rd_mem(adr[0], d[0]);
      wr(OFS_GUARD, 8'h00);
      // Row erase, byte erase, then odd and even half-array program
      i_nv_cpu_model.nv_op(8'h0e, 16'h0d8a, 8'h00);
      rd_mem(adr[0], ERASED);
      rd_mem(adr[1], ERASED);
      rd_mem(adr[2], d[2]);
      i_nv_cpu_model.nv_op(8'h16, adr[2], 8'h00);
      rd_mem(adr[2], ERASED);
      rd_mem(adr[3], d[3]);
      i_nv_cpu_model.nv_op(8'hc2, 16'h0d8a, 8'h5a);
      rd_mem(16'h0d9a, 8'h5a);
      rd_mem(16'h0eca, ERASED);
      done("guard and erase");
      // Setup cell: erase, program, then reset; latch holds old value until then
      i_nv_cpu_model.prog(16'h003f, 8'hc2);
      rd_reg(OFS_SETUP, SETUP_FORCE | 8'h01);
      @(posedge core_clk_i);
      pulse_reset();
      rd_reg(OFS_SETUP, 8'hc2);
      rd_mem(adr[3], 8'h00, 1'b0);
      done("setup program");
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
